// ===== edtd_params.svh
`ifndef EDTD_PARAMS_SVH
`define EDTD_PARAMS_SVH
`define EDTD_RECORD_CODE 8'h09
`define EDTD_END_MARK 8'hFF
`define EDTD_CONT_BIT 7
`define EDTD_LOC_BIT 2
`define EDTD_WIDE_BIT 3
`define EDTD_PS_64M 2'h0
`define EDTD_PS_32M 2'h1
`define EDTD_PS_16M 2'h2
`define EDTD_PS_RSVD 2'h3
`define EDTD_CODE_EXT 3'h7
`define EDTD_UNIT_SHIFT0 5'h09
`define EDTD_PAGE_SHIFT 6'h1A
`define EDTD_RST_BYTE 8'h00
`endif

// ===== edtd_pkg.sv
package edtd_pkg;
    typedef struct packed {
        logic [1:0] page_size;
        logic addr_src_cfg;
        logic [4:0] ext_bits;
        logic [3:0] ext_regs;
        logic valid;
    } edtd_paging_t;
    typedef struct packed {
        logic [7:0] id_byte;
        logic [15:0] multiplier;
        logic [4:0] units_m1;
        logic [2:0] size_code;
        logic [47:0] size_bytes;
    } edtd_entry_t;
endpackage

// ===== edtd_size_calc.sv
`timescale 1ns/1ns
`include "edtd_params.svh"
module edtd_size_calc (
    input wire logic [15:0] mult_in, // Page multiplier
    input wire logic [7:0] size_byte_in, // Single or final size byte
    output logic [47:0] size_out // Size in bytes
);
    logic [47:0] base;
    logic [47:0] units;
    always_comb begin
        // Unit = 512 bytes times four per code step
        base = 48'h1 << (`EDTD_UNIT_SHIFT0 + {size_byte_in[2:0], 1'b0});
        units = {43'h0, size_byte_in[7:3]} + 48'h1;
        size_out = (48'(mult_in) << `EDTD_PAGE_SHIFT) + units * base;
    end
endmodule // edtd_size_calc

// ===== edtd_decoder.sv
`timescale 1ns/1ns
`include "edtd_params.svh"
module edtd_decoder
    import edtd_pkg::*;
(
    input wire logic ref_clk_in, // 50 MHz clock
    input wire logic rst_n_in, // Synchronous reset, active low
    input wire logic start_in, // Begin decoding a record
    input wire logic byte_valid_in, // Record byte present
    input wire logic [7:0] byte_in, // Record byte
    output logic byte_ready_out, // Ready for a byte, high while busy
    output edtd_pkg::edtd_paging_t paging_out, // Decoded paging info
    output edtd_pkg::edtd_entry_t entry_out, // Decoded device entry
    output logic entry_valid_out, // Entry pulse
    output logic done_out, // Record finished, level
    output logic error_out, // Malformed record, sticky
    output logic [7:0] entry_count_out // Entries decoded
);
    import edtd_pkg::*;

    typedef enum logic [9:0] {
        S_IDLE = 10'b0000000001,
        S_CODE = 10'b0000000010,
        S_LINK = 10'b0000000100,
        S_PAGE = 10'b0000001000,
        S_PAGEX = 10'b0000010000,
        S_ID = 10'b0000100000,
        S_SIZE = 10'b0001000000,
        S_MUL0 = 10'b0010000000,
        S_MUL1 = 10'b0100000000,
        S_FINAL = 10'b1000000000
    } edtd_state_t;

    edtd_state_t state_ff, nxt_state;
    logic [7:0] link_ff;
    logic [7:0] offset_ff;
    logic wide_ff;
    logic [15:0] mult_ff;
    logic [7:0] id_ff;
    logic id_more_ff;
    logic done_ff;
    logic error_ff;
    logic entry_valid_ff;
    logic [7:0] count_ff;
    edtd_paging_t paging_ff;
    edtd_entry_t entry_ff;
    logic [47:0] calc_size;
    logic [15:0] calc_mult;
    logic take;
    logic busy;
    logic overrun;
    logic is_ext;

    function automatic logic is_extender(input logic [7:0] b);
        is_extender = (b[2:0] == `EDTD_CODE_EXT) && (b[7:4] == 4'h0);
    endfunction

    function automatic logic [3:0] regs_for(input logic [1:0] ps, input logic loc);
        case (ps)
            `EDTD_PS_64M: regs_for = loc ? 4'h0 : 4'h1;
            `EDTD_PS_32M: regs_for = 4'h3;
            `EDTD_PS_16M: regs_for = 4'hF;
            default: regs_for = 4'h0;
        endcase
    endfunction

    assign busy = (state_ff != S_IDLE);
    assign byte_ready_out = busy;
    assign take = busy && byte_valid_in;
    assign is_ext = is_extender(byte_in);
    // Offset beyond link plus one runs past the record
    assign overrun = (state_ff != S_CODE) && (state_ff != S_LINK)
        && (offset_ff > link_ff + 8'h01);
    assign calc_mult = (state_ff == S_FINAL) ? mult_ff : 16'h0;

    edtd_size_calc u_size (
        .mult_in(calc_mult),
        .size_byte_in(byte_in),
        .size_out(calc_size)
    );

    always_comb begin
        nxt_state = state_ff;
        if (take) begin
            case (state_ff)
                S_CODE: nxt_state = S_LINK;
                S_LINK: nxt_state = S_PAGE;
                S_PAGE, S_PAGEX: begin
                    nxt_state = byte_in[`EDTD_CONT_BIT] ? S_PAGEX : S_ID;
                end
                S_ID: begin
                    // Device ID bytes chain via bit 7 of the extension byte
                    nxt_state = (id_more_ff || byte_in[3:0] == 4'hE) ? S_ID : S_SIZE;
                    if (!id_more_ff && byte_in == `EDTD_END_MARK) begin
                        nxt_state = S_IDLE;
                    end
                end
                S_SIZE: begin
                    if (byte_in == `EDTD_END_MARK) begin
                        nxt_state = S_IDLE;
                    end else if (is_ext) begin
                        nxt_state = S_MUL0;
                    end else begin
                        nxt_state = S_ID;
                    end
                end
                S_MUL0: nxt_state = wide_ff ? S_MUL1 : S_FINAL;
                S_MUL1: nxt_state = S_FINAL;
                S_FINAL: begin
                    nxt_state = (byte_in == `EDTD_END_MARK) ? S_IDLE : S_ID;
                end
                default: nxt_state = S_IDLE;
            endcase
        end
        if (!rst_n_in) begin
            nxt_state = S_IDLE;
        end else if (start_in && !busy) begin
            nxt_state = S_CODE;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        state_ff <= nxt_state;
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in || (start_in && !busy)) begin
            offset_ff <= `EDTD_RST_BYTE;
            link_ff <= `EDTD_RST_BYTE;
        end else if (take) begin
            offset_ff <= offset_ff + 8'h01;
            if (state_ff == S_LINK) begin
                link_ff <= byte_in;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in || (start_in && !busy)) begin
            paging_ff <= '0;
        end else if (take && state_ff == S_PAGE) begin
            paging_ff.page_size <= byte_in[1:0];
            paging_ff.addr_src_cfg <= byte_in[`EDTD_LOC_BIT];
            paging_ff.ext_bits <= {1'b0, byte_in[6:3]} + 5'h01;
            paging_ff.ext_regs <= regs_for(byte_in[1:0], byte_in[`EDTD_LOC_BIT]);
            paging_ff.valid <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            id_ff <= `EDTD_RST_BYTE;
            id_more_ff <= 1'b0;
        end else if (take && state_ff == S_ID) begin
            if (!id_more_ff) begin
                id_ff <= byte_in;
            end
            id_more_ff <= (id_more_ff || byte_in[3:0] == 4'hE) ? byte_in[7] : 1'b0;
            if (!id_more_ff && byte_in[3:0] == 4'hE) begin
                id_more_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            wide_ff <= 1'b0;
            mult_ff <= 16'h0;
        end else if (take) begin
            case (state_ff)
                S_SIZE: begin
                    wide_ff <= byte_in[`EDTD_WIDE_BIT];
                    mult_ff <= 16'h0;
                end
                S_MUL0: mult_ff[7:0] <= byte_in;
                S_MUL1: mult_ff[15:8] <= byte_in;
                default: mult_ff <= mult_ff;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            entry_ff <= '0;
            entry_valid_ff <= 1'b0;
            count_ff <= 8'h00;
        end else begin
            entry_valid_ff <= 1'b0;
            if (start_in && !busy) begin
                count_ff <= 8'h00;
            end
            // End marker entries are dropped, nothing published
            if (take && byte_in != `EDTD_END_MARK && ((state_ff == S_SIZE && !is_ext)
                || state_ff == S_FINAL)) begin
                entry_ff.id_byte <= id_ff;
                entry_ff.multiplier <= calc_mult;
                entry_ff.units_m1 <= byte_in[7:3];
                entry_ff.size_code <= byte_in[2:0];
                entry_ff.size_bytes <= calc_size;
                entry_valid_ff <= 1'b1;
                count_ff <= count_ff + 8'h01;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in || (start_in && !busy)) begin
            done_ff <= 1'b0;
        end else if (take && nxt_state == S_IDLE) begin
            done_ff <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in || (start_in && !busy)) begin
            error_ff <= 1'b0;
        end else if (take) begin
            case (state_ff)
                S_CODE: begin
                    if (byte_in != `EDTD_RECORD_CODE) begin
                        error_ff <= 1'b1;
                    end
                end
                S_PAGE: begin
                    if (byte_in[1:0] == `EDTD_PS_RSVD) begin
                        error_ff <= 1'b1;
                    end
                    if (byte_in[1:0] != `EDTD_PS_64M && byte_in[`EDTD_LOC_BIT]) begin
                        error_ff <= 1'b1;
                    end
                end
                S_PAGEX: begin
                    if (byte_in[6:0] != 7'h00) begin
                        error_ff <= 1'b1;
                    end
                end
                S_FINAL: begin
                    if (byte_in != `EDTD_END_MARK && byte_in[2:0] == `EDTD_CODE_EXT) begin
                        error_ff <= 1'b1;
                    end
                end
                default: error_ff <= error_ff;
            endcase
            if (overrun) begin
                error_ff <= 1'b1;
            end
        end
    end

    assign paging_out = paging_ff;
    assign entry_out = entry_ff;
    assign entry_valid_out = entry_valid_ff;
    assign done_out = done_ff;
    assign error_out = error_ff;
    assign entry_count_out = count_ff;
endmodule // edtd_decoder

// ===== edtd_decoder_checker.sv
`timescale 1ns/1ns
module edtd_decoder_checker
    import edtd_pkg::*;
(
    input wire logic ref_clk_in, // Clock
    input wire logic rst_n_in, // Reset
    input wire logic start_in, // Start
    input wire logic byte_ready_out, // Busy
    input wire edtd_pkg::edtd_paging_t paging_out, // Paging
    input wire edtd_pkg::edtd_entry_t entry_out, // Entry
    input wire logic entry_valid_out, // Entry pulse
    input wire logic done_out, // Done
    input wire logic error_out, // Error
    input wire logic [7:0] entry_count_out // Count
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_start_taken;
        !byte_ready_out && start_in;
    endsequence
    sequence s_fresh_record;
        byte_ready_out && !done_out && !error_out && entry_count_out == 8'h00;
    endsequence
    a_start_opens: assert property (s_start_taken |=> s_fresh_record)
        else $error("start not taken cleanly");
    a_entry_single: assert property (entry_valid_out |=> !entry_valid_out)
        else $error("entry pulse too long");
    a_size_formula: assert property (entry_valid_out && entry_out.size_code != 3'h7 |->
        entry_out.size_bytes == (48'(entry_out.multiplier) << 26)
        + ((48'(entry_out.units_m1) + 48'h1) << (9 + 2 * entry_out.size_code)))
        else $error("entry size wrong");
    a_done_idle: assert property (done_out |-> !byte_ready_out && !entry_valid_out)
        else $error("done while busy");
    a_regs_big_page: assert property (paging_out.valid && paging_out.page_size == 2'h0
        |-> paging_out.ext_regs == {3'h0, !paging_out.addr_src_cfg})
        else $error("64M register mask wrong");
    a_regs_small_page: assert property (paging_out.valid && paging_out.page_size inside
        {2'h1, 2'h2} |-> paging_out.ext_regs == (paging_out.page_size[0] ? 4'h3 : 4'hF))
        else $error("small page register mask wrong");
    a_width_plus_one: assert property (paging_out.valid |->
        paging_out.ext_bits inside {[5'h01:5'h10]})
        else $error("extension width out of range");
    a_rsvd_page: assert property (paging_out.valid && paging_out.page_size == 2'h3
        |-> ##[0:1] error_out)
        else $error("reserved page size unflagged");
    a_error_sticky: assert property (error_out && !start_in |=> error_out)
        else $error("error dropped");
    a_final_seven: assert property (entry_valid_out && entry_out.size_code == 3'h7
        |-> ##[0:1] error_out)
        else $error("final code 7 unflagged");
endmodule // edtd_decoder_checker
bind edtd_decoder edtd_decoder_checker i_edtd_decoder_checker (.ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in), .start_in(start_in), .byte_ready_out(byte_ready_out),
    .paging_out(paging_out), .entry_out(entry_out), .entry_valid_out(entry_valid_out),
    .done_out(done_out), .error_out(error_out), .entry_count_out(entry_count_out));

// ===== edtd_card_mem.sv
`timescale 1ns/1ns
module edtd_card_mem (
    input wire logic clk_in, // Clock
    input wire logic rst_n_in, // Reset
    input wire logic go_in, // Rewind to offset 0
    input wire logic slow_in, // Gap after each byte
    input wire logic ready_in, // Decoder takes byte
    output logic valid_out = 1'b0, // Byte presented
    output logic [7:0] byte_out = 8'h00 // Record byte
);
    logic [7:0] mem [0:31];
    int len = 0;
    int pos = 0;
    always @(posedge clk_in) begin
        if (!rst_n_in || go_in) begin
            pos <= 0; // Offset 0 first
            valid_out <= #1 1'b0;
        end else if (valid_out && ready_in) begin
            pos <= pos + 1;
            valid_out <= #1 (pos + 1 < len) && !slow_in;
            byte_out <= #1 (pos + 1 < len && !slow_in) ? mem[pos + 1] : ~byte_out;
        end else if (!valid_out && pos < len) begin
            valid_out <= #1 1'b1;
            byte_out <= #1 mem[pos];
        end
    end
endmodule // edtd_card_mem

// ===== edtd_decoder_test.sv
`timescale 1ns/1ns
module edtd_decoder_test;
    import edtd_pkg::*;
    logic ref_clk_in = 1'b0, rst_n_in = 1'b0, start_in = 1'b0, go = 1'b0, slow = 1'b0;
    logic mvalid, ready, entry_valid, done, error;
    logic [7:0] mbyte, count;
    edtd_paging_t paging;
    edtd_entry_t entry;
    edtd_entry_t got[$];
    int err_count = 0, total_checks = 0, cyc = 0;
    edtd_card_mem i_edtd_card_mem (.clk_in(ref_clk_in), .rst_n_in(rst_n_in), .go_in(go),
        .slow_in(slow), .ready_in(ready), .valid_out(mvalid), .byte_out(mbyte));
    edtd_decoder i_edtd_decoder (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .start_in(start_in), .byte_valid_in(mvalid), .byte_in(mbyte), .byte_ready_out(ready),
        .paging_out(paging), .entry_out(entry), .entry_valid_out(entry_valid),
        .done_out(done), .error_out(error), .entry_count_out(count));
    always #10 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        cyc++;
        if (entry_valid === 1'b1) got.push_back(entry);
        if (cyc > 3000) begin
            err_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] act);
        total_checks++;
        if (act !== exp) begin
            err_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, act);
        end
    endtask
    task automatic reset(input int n);
        rst_n_in = 1'b0;
        repeat (n) @(posedge ref_clk_in);
        #1 rst_n_in = 1'b1;
    endtask
    task automatic run(input logic [7:0] b[$], input logic s);
        int n;
        slow = s;
        foreach (b[i]) i_edtd_card_mem.mem[i] = b[i];
        i_edtd_card_mem.len = b.size();
        got.delete();
        start_in = 1'b1;
        go = 1'b1;
        @(posedge ref_clk_in);
        #1 start_in = 1'b0;
        go = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 100) begin
            @(posedge ref_clk_in);
            #1 n++;
        end
        // A record that never ends counts as a mismatch
        if (done !== 1'b1) begin
            err_count++;
            $display("ERROR done expected 1 seen %b", done);
        end
        repeat (2) @(posedge ref_clk_in);
        #1;
    endtask
    task automatic bad(input logic [7:0] b[$]);
        reset(2);
        run(b, 1'b0);
        check("error", 1, error);
    endtask
    initial begin
        reset(20);
        run('{8'h09, 8'h08, 8'h04, 8'h41, 8'h07, 8'h01, 8'hF6, 8'h42, 8'h0A, 8'hFF}, 1'b0);
        check("page_size", 0, paging.page_size);
        check("addr_src", 1, paging.addr_src_cfg);
        check("ext_bits", 1, paging.ext_bits);
        check("entries", 2, got.size());
        check("mult_lo", 1, got[0].multiplier);
        check("id_one", 8'h41, got[0].id_byte);
        check("units_fin", 5'h1E, got[0].units_m1);
        check("code_fin", 3'h6, got[0].size_code);
        check("paging_valid", 1, paging.valid);
        check("size_ext", 64'h7E00000, got[0].size_bytes);
        check("id_two", 8'h42, got[1].id_byte);
        check("size_one", 64'h4000, got[1].size_bytes);
        check("count", 2, count);
        check("done", 1, done);
        check("error", 0, error);
        run('{8'h09, 8'h09, 8'hB2, 8'h00, 8'h43, 8'h0F, 8'h34, 8'h12, 8'h00, 8'h44,
            8'hFF}, 1'b1);
        check("page_size", 2, paging.page_size);
        check("ext_bits", 7, paging.ext_bits);
        check("ext_regs", 4'hF, paging.ext_regs);
        check("entries", 1, got.size());
        check("mult", 16'h1234, got[0].multiplier);
        check("size_wide", 64'h48D0000200, got[0].size_bytes);
        check("count", 1, count);
        check("error", 0, error);
        bad('{8'h09, 8'h05, 8'h05, 8'h41, 8'h0A, 8'hFF});
        bad('{8'h09, 8'h05, 8'h03, 8'h41, 8'h0A, 8'hFF});
        bad('{8'h09, 8'h06, 8'h80, 8'h01, 8'h41, 8'h0A, 8'hFF});
        bad('{8'h09, 8'h06, 8'h00, 8'h41, 8'h07, 8'h01, 8'h07, 8'hFF});
        bad('{8'h09, 8'h02, 8'h00, 8'h41, 8'h0A, 8'hFF});
        bad('{8'h0A, 8'h04, 8'h00, 8'h41, 8'h0A, 8'hFF});
        report_and_stop();
    end
endmodule // edtd_decoder_test
